// file: tocp_cfg.svh
// offsets, field positions, reset values and codes of the timer output block
`ifndef TOCP_CFG_SVH
`define TOCP_CFG_SVH
// register byte offsets (low address byte)
`define TOCP_OFF_CTRL 8'h00
`define TOCP_OFF_PSC 8'h04
`define TOCP_OFF_ARR 8'h08
`define TOCP_OFF_IER 8'h0C
`define TOCP_OFF_DTB 8'h10
`define TOCP_OFF_OEP 8'h14
`define TOCP_OFF_IDLE 8'h18
`define TOCP_OFF_MODE 8'h1C
`define TOCP_OFF_CCR1 8'h20
`define TOCP_OFF_STAT 8'h38
`define TOCP_OFF_CNT 8'h3C
// control word fields
`define TOCP_CTRL_DIR 4
`define TOCP_CTRL_CMS 5
`define TOCP_CTRL_CKD 8
`define TOCP_CTRL_IDIR 10
// group-combine bits in the channel-5 compare word
`define TOCP_GC_LO 29
// reset values
`define TOCP_RST_ARR 32'h0000FFFF
`define TOCP_RST_ZERO 32'h00000000
// output mode codes
`define TOCP_OCM_FROZEN 4'h0
`define TOCP_OCM_SET 4'h1
`define TOCP_OCM_CLR 4'h2
`define TOCP_OCM_TOG 4'h3
`define TOCP_OCM_LOW 4'h4
`define TOCP_OCM_HIGH 4'h5
`define TOCP_OCM_PWM1 4'h6
`define TOCP_OCM_PWM2 4'h7
`define TOCP_OCM_CMB1 4'hC
`define TOCP_OCM_CMB2 4'hD
`define TOCP_OCM_ASY1 4'hE
`define TOCP_OCM_ASY2 4'hF
// dead-time counter width in base ticks
`define TOCP_DT_W 10
`endif

// file: tocp_pkg.sv
// types shared by the timer output block
package tocp_pkg;
  // counter alignment modes, in field order
  typedef enum logic [1:0] {TOCP_EDGE, TOCP_CTR1, TOCP_CTR2, TOCP_CTR3} tocp_cms_t;
  // one channel mode field
  typedef logic [3:0] tocp_mode_t;
endpackage

// file: tocp_timer.sv
// timer output compare and pwm block with ahb-lite register slave
//
// Behaviour
// - sync rise clears counter, loads pending config
// - compare and update flags are single pulses
// - update and channel 1-4 flags gated by their enable bits
// - channel 5 and 6 flags always enabled
// - references derived from counter compare matches
// - frozen, set, clear, toggle on match
// - forced low/high, pwm mode 1 and 2
// - combined and asymmetric modes; 1000-1011 unsupported
// - mode fields take effect at update event
// - group-combine ANDs channels 1-3 with channel 5
// - channel-5 word with combine bits is preloaded
// - no break or clear; main enable always set
// - enable/polarity word acts immediately
// - advanced: 16-bit counter, edge and center modes
// - channels 5 and 6 internal only
// - polarity bit 1 inverts output
// - disabled output shows its idle level
// - enable pair selects main, complementary, both
// - dead time at every rising output edge of channels 1-3 while both outputs of the pair are enabled
// - dead-time length from generator field
// - clock-division sets dead-time base tick
// - general subtype: polarity only, no complementary
// - period, compare, mode and combine words loaded only at update events and sync rises
`timescale 1ns/1ps
`include "tocp_cfg.svh"

module tocp_timer
  import tocp_pkg::*;
#(
  parameter bit ADVANCED = 1'b1,
  parameter int CNT_W = 16
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sync_in,
  output logic [3:0] main_output,
  output logic [2:0] compl_output,
  output logic [5:0] compare_flag_out,
  output logic update_flag_out
);

  // ==========================================================
  // register state
  logic [31:0] ctrl; // control_word_one
  logic [15:0] psc; // prescaler
  logic [15:0] interrupt_enable; // flag gating
  logic [7:0] dtg; // dead-time generator field
  logic [31:0] oep; // output_enable_polarity_word, not preloaded
  logic [6:0] idle; // idle level per output
  logic [CNT_W-1:0] arr_pend; // pending period
  logic [CNT_W-1:0] arr_act; // active period
  logic [23:0] mode_pend; // pending mode fields
  logic [23:0] mode_act; // active mode fields
  logic [CNT_W-1:0] ccr_pend [0:5]; // pending compare values
  logic [CNT_W-1:0] ccr_act [0:5]; // active compare values
  logic [2:0] gc_pend; // pending group-combine bits
  logic [2:0] gc_act; // active group-combine bits
  logic bus_wr; // data phase of a write pending
  logic [7:0] bus_addr; // latched address
  logic take; // address phase accepted

  // ==========================================================
  // ahb-lite slave
  assign hreadyout = ce; // stall only while frozen
  assign hresp = 1'b0; // always okay
  assign take = ce && hready && hsel && htrans[1];

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_wr <= 1'b0;
      bus_addr <= 8'h00;
    end
    else if (ce && hready)
    begin
      bus_wr <= take && hwrite;
      bus_addr <= haddr[7:0];
    end
  end

  // ==========================================================
  // prescaler and counter
  logic [15:0] psc_cnt; // prescale divider
  logic tick; // counter clock enable
  logic [CNT_W-1:0] cnt; // counter_value
  logic cnt_down; // counting direction
  logic [CNT_W-1:0] next_cnt;
  logic next_down;
  logic wrap; // overflow or underflow on this tick
  logic uev; // update event
  logic sync_q; // previous sync level
  logic sync_rise; // rising edge of sync
  logic load; // move pending config to active
  tocp_cms_t cms;

  assign cms = tocp_cms_t'(ctrl[`TOCP_CTRL_CMS +: 2]);
  assign tick = ce && (psc_cnt >= psc);
  assign sync_rise = sync_in && !sync_q;
  assign uev = tick && wrap;
  assign load = ce && (uev || sync_rise);

  // prescaler divider
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      psc_cnt <= 16'h0000;
    else if (ce)
      psc_cnt <= (psc_cnt >= psc) ? 16'h0000 : psc_cnt + 16'h0001;
  end

  // next counter value, edge and center alignment
  always_comb
  begin
    next_cnt = cnt;
    next_down = cnt_down;
    wrap = 1'b0;
    if (cms == TOCP_EDGE)
    begin
      next_down = ctrl[`TOCP_CTRL_DIR];
      if (!ctrl[`TOCP_CTRL_DIR])
      begin
        wrap = (cnt == arr_act);
        next_cnt = wrap ? '0 : cnt + 1'b1;
      end
      else
      begin
        wrap = (cnt == '0);
        next_cnt = wrap ? arr_act : cnt - 1'b1;
      end
    end
    else if (!cnt_down)
    begin
      wrap = (cnt >= arr_act); // overflow turns round
      next_down = wrap;
      next_cnt = wrap ? cnt - 1'b1 : cnt + 1'b1;
    end
    else
    begin
      wrap = (cnt == '0); // underflow turns round
      next_down = !wrap;
      next_cnt = wrap ? cnt + 1'b1 : cnt - 1'b1;
    end
  end

  // counter register, sync wins over counting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= '0;
      cnt_down <= 1'b0;
      sync_q <= 1'b0;
    end
    else if (ce)
    begin
      sync_q <= sync_in;
      if (sync_rise)
      begin
        cnt <= '0;
        cnt_down <= ctrl[`TOCP_CTRL_IDIR] && (cms != TOCP_EDGE);
      end
      else if (tick)
      begin
        cnt <= next_cnt;
        cnt_down <= next_down;
      end
    end
  end

  // ==========================================================
  // register writes and preload
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= `TOCP_RST_ZERO;
      psc <= 16'h0000;
      interrupt_enable <= 16'h0000;
      dtg <= 8'h00;
      oep <= `TOCP_RST_ZERO;
      idle <= 7'h00;
      arr_pend <= CNT_W'(`TOCP_RST_ARR);
      mode_pend <= 24'h000000;
      gc_pend <= 3'h0;
      for (int i = 0; i < 6; i++)
        ccr_pend[i] <= '0;
    end
    else if (ce && bus_wr)
    begin
      unique case (bus_addr)
        `TOCP_OFF_CTRL: ctrl <= hwdata;
        `TOCP_OFF_PSC: psc <= hwdata[15:0];
        `TOCP_OFF_ARR: arr_pend <= hwdata[CNT_W-1:0];
        `TOCP_OFF_IER: interrupt_enable <= hwdata[15:0];
        `TOCP_OFF_DTB: dtg <= hwdata[7:0]; // main enable bit ignored
        `TOCP_OFF_OEP: oep <= hwdata;
        `TOCP_OFF_IDLE: idle <= hwdata[6:0];
        `TOCP_OFF_MODE: mode_pend <= hwdata[23:0];
        default:
        begin
          // compare words occupy six consecutive offsets
          for (int i = 0; i < 6; i++)
            if (bus_addr == `TOCP_OFF_CCR1 + 8'(4 * i))
              ccr_pend[i] <= hwdata[CNT_W-1:0];
          if (bus_addr == `TOCP_OFF_CCR1 + 8'h10)
            gc_pend <= hwdata[`TOCP_GC_LO +: 3];
        end
      endcase
    end
  end

  // active copies change only on update event or sync
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      arr_act <= CNT_W'(`TOCP_RST_ARR);
      mode_act <= 24'h000000;
      gc_act <= 3'h0;
      for (int i = 0; i < 6; i++)
        ccr_act[i] <= '0;
    end
    else if (load)
    begin
      arr_act <= arr_pend;
      mode_act <= mode_pend;
      gc_act <= gc_pend;
      for (int i = 0; i < 6; i++)
        ccr_act[i] <= ccr_pend[i];
    end
  end

  // ==========================================================
  // compare matches and flag pulses
  logic [5:0] cmp_hit; // match on this tick
  logic dir_ok; // flag allowed in this direction
  logic [5:0] flag_en; // per-channel flag enable

  always_comb
  begin
    unique case (cms)
      TOCP_EDGE: dir_ok = 1'b1;
      TOCP_CTR1: dir_ok = cnt_down;
      TOCP_CTR2: dir_ok = !cnt_down;
      TOCP_CTR3: dir_ok = 1'b1;
    endcase
  end

  assign flag_en = {2'b11, interrupt_enable[4:1]};

  // one-cycle flag pulses
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      compare_flag_out <= 6'h00;
      update_flag_out <= 1'b0;
    end
    else if (ce)
    begin
      compare_flag_out <= cmp_hit & flag_en;
      update_flag_out <= uev && interrupt_enable[0];
    end
  end

  // ==========================================================
  // output-mode controller, six references
  logic [5:0] ref_lvl; // channel_reference
  logic [5:0] pwm_lvl; // counter below compare value

  for (genvar i = 0; i < 6; i++)
  begin : g_ref
    localparam int P = i ^ 1; // partner channel
    logic ref_q;
    tocp_mode_t md;
    assign md = mode_act[4*i +: 4];
    assign pwm_lvl[i] = (cnt < ccr_act[i]);
    assign cmp_hit[i] = tick && dir_ok && (cnt == ccr_act[i]);
    assign ref_lvl[i] = ref_q;

    // reference update per counter tick
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        ref_q <= 1'b0;
      else if (tick)
      begin
        unique case (md)
          `TOCP_OCM_FROZEN: ref_q <= ref_q;
          `TOCP_OCM_SET: ref_q <= ref_q || cmp_hit[i];
          `TOCP_OCM_CLR: ref_q <= ref_q && !cmp_hit[i];
          `TOCP_OCM_TOG: ref_q <= ref_q ^ cmp_hit[i];
          `TOCP_OCM_LOW: ref_q <= 1'b0;
          `TOCP_OCM_HIGH: ref_q <= 1'b1;
          `TOCP_OCM_PWM1: ref_q <= pwm_lvl[i];
          `TOCP_OCM_PWM2: ref_q <= !pwm_lvl[i];
          `TOCP_OCM_CMB1: ref_q <= pwm_lvl[i] || pwm_lvl[P];
          `TOCP_OCM_CMB2: ref_q <= !pwm_lvl[i] && !pwm_lvl[P];
          `TOCP_OCM_ASY1: ref_q <= cnt_down ? (cnt < ccr_act[P]) : pwm_lvl[i];
          `TOCP_OCM_ASY2: ref_q <= cnt_down ? (cnt >= ccr_act[P]) : !pwm_lvl[i];
          default: ref_q <= ref_q; // unsupported codes hold
        endcase
      end
    end
  end

  // gated references, channels 5 and 6 stay internal
  logic [3:0] gref; // gated_channel_reference
  for (genvar i = 0; i < 3; i++)
  begin : g_gate
    assign gref[i] = ref_lvl[i] && !(ADVANCED && gc_act[i] && !ref_lvl[4]);
  end
  assign gref[3] = ref_lvl[3];

  // ==========================================================
  // dead-time length in counter ticks
  logic [1:0] ckd_sh; // deadtime_base_tick as a shift of counter ticks
  logic [`TOCP_DT_W-1:0] dt_len; // dead time in base ticks
  logic [`TOCP_DT_W+1:0] dt_ticks; // dead time in counter ticks
  logic [7:0] g; // generator alias

  assign g = dtg;
  // clock division 00 = 1, 01 = 2, 10 = 4 counter ticks; 11 acts as 4
  assign ckd_sh = ctrl[`TOCP_CTRL_CKD + 1] ? 2'h2 : {1'b0, ctrl[`TOCP_CTRL_CKD]};
  // whole counter ticks keep the length exact, free of any divider phase
  assign dt_ticks = {2'b00, dt_len} << ckd_sh;

  // generator decode
  always_comb
  begin
    if (!g[7])
      dt_len = {2'b00, g};
    else if (!g[6])
      dt_len = {2'b00, 1'b1, g[5:0], 1'b0};
    else if (!g[5])
      dt_len = {1'b0, 1'b1, g[4:0], 3'b000};
    else
      dt_len = {1'b1, g[4:0], 4'b0000};
  end

  // ==========================================================
  // output stages
  logic [`TOCP_DT_W+1:0] dt_cnt [0:2]; // remaining dead time in counter ticks
  logic [2:0] ref_d; // reference behind dead time
  logic [2:0] pair_on; // both outputs of pair enabled

  for (genvar i = 0; i < 3; i++)
  begin : g_dt
    assign pair_on[i] = oep[4*i] && oep[4*i+2];

    // restart dead time on each reference edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        ref_d[i] <= 1'b0;
        dt_cnt[i] <= '0;
      end
      else if (ce)
      begin
        if (gref[i] != ref_d[i])
        begin
          ref_d[i] <= gref[i];
          dt_cnt[i] <= dt_ticks;
        end
        else if (tick && dt_cnt[i] != '0)
          dt_cnt[i] <= dt_cnt[i] - 1'b1;
      end
    end

    // main and complementary output of channels 1 to 3
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        main_output[i] <= 1'b0;
        compl_output[i] <= 1'b0;
      end
      else if (ce)
      begin
        if (!oep[4*i])
          main_output[i] <= idle[2*i];
        else if (ADVANCED && pair_on[i])
          main_output[i] <= (ref_d[i] && dt_cnt[i] == '0) ^ oep[4*i+1];
        else
          main_output[i] <= gref[i] ^ oep[4*i+1];
        if (!ADVANCED || !oep[4*i+2])
          compl_output[i] <= idle[2*i+1];
        else if (pair_on[i])
          compl_output[i] <= (!ref_d[i] && dt_cnt[i] == '0) ^ oep[4*i+3];
        else
          compl_output[i] <= gref[i] ^ oep[4*i+3];
      end
    end
  end

  // channel 4, main output only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      main_output[3] <= 1'b0;
    else if (ce)
      main_output[3] <= oep[12] ? (gref[3] ^ oep[13]) : idle[6];
  end

  // ==========================================================
  // read data, taken in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (take && !hwrite)
    begin
      hrdata <= 32'h00000000;
      unique case (haddr[7:0])
        `TOCP_OFF_CTRL: hrdata <= ctrl;
        `TOCP_OFF_PSC: hrdata <= {16'h0000, psc};
        `TOCP_OFF_ARR: hrdata <= 32'(arr_pend);
        `TOCP_OFF_IER: hrdata <= {16'h0000, interrupt_enable};
        `TOCP_OFF_DTB: hrdata <= {24'h000000, dtg};
        `TOCP_OFF_OEP: hrdata <= oep;
        `TOCP_OFF_IDLE: hrdata <= {25'h0000000, idle};
        `TOCP_OFF_MODE: hrdata <= {8'h00, mode_pend};
        `TOCP_OFF_STAT: hrdata <= {23'h000000, cnt_down, 2'b00, ref_lvl};
        `TOCP_OFF_CNT: hrdata <= 32'(cnt);
        default:
        begin
          for (int i = 0; i < 6; i++)
            if (haddr[7:0] == `TOCP_OFF_CCR1 + 8'(4 * i))
              hrdata <= 32'(ccr_pend[i]);
          if (haddr[7:0] == `TOCP_OFF_CCR1 + 8'h10)
            hrdata[`TOCP_GC_LO +: 3] <= gc_pend;
        end
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_SYNC_CLR: assert property (ce && sync_rise |=> cnt == '0)
    else $error("sync did not clear counter");
  AST_UPD_PULSE: assert property (uev && interrupt_enable[0] |=> update_flag_out)
    else $error("update flag pulse missing");
  AST_UPD_MASK: assert property (ce && !interrupt_enable[0] |=> !update_flag_out)
    else $error("masked update flag seen");
  AST_CH5_FLAG: assert property (cmp_hit[4] |=> compare_flag_out[4])
    else $error("channel 5 flag not passed");
  AST_FORCE_LOW: assert property (tick && mode_act[3:0] == `TOCP_OCM_LOW |=> !ref_lvl[0])
    else $error("forced low reference high");
  AST_PRELOAD: assert property (!load |=> $stable(mode_act))
    else $error("mode changed without update");
  AST_COMBINE: assert property (ADVANCED && gc_act[0] && !ref_lvl[4] |-> !gref[0])
    else $error("combine gate not applied");
  AST_IDLE: assert property (ce && !oep[0] |=> main_output[0] == $past(idle[0]))
    else $error("disabled output not idle");
  AST_IMMEDIATE: assert property (ce && oep[0] && !oep[2] |=>
    main_output[0] == ($past(gref[0]) ^ $past(oep[1])))
    else $error("enable word not immediate");
  AST_NO_OVERLAP: assert property (ce && pair_on[0] && oep[1] == 1'b0 && oep[3] == 1'b0 |=>
    !(main_output[0] && compl_output[0]))
    else $error("main and complementary both active");

  COV_UEV: cover property (uev);
  COV_SYNC: cover property (ce && sync_rise);
  COV_DEADTIME: cover property (pair_on[0] && dt_cnt[0] != '0);
endmodule

// file: tocp_gate_model.sv
// gate driver model of the power stage behind the pwm outputs
`timescale 1ns/1ps

module tocp_gate_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] main_output,
  input wire logic [2:0] compl_output,
  input wire logic [2:0] pair_on,
  output int overlap_count
);
  // ==========
  // shoot-through watch
  // ==========
  // both gates of one leg on at once would short the supply
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      overlap_count <= 0;
    end
    else if ((main_output[2:0] & compl_output & pair_on) != 3'h0)
    begin
      overlap_count <= overlap_count + 1;
    end
  end
endmodule

// file: testbench.sv
// self-checking testbench of the timer output block
`timescale 1ns/1ps
`include "tocp_cfg.svh"

module testbench;
  // ==========
  // stimulus and observed signals
  // ==========
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sync_in = 1'b0;
  logic [2:0] pair_on = 3'h0; // legs in complementary mode
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] main_output;
  logic [2:0] compl_output;
  logic [5:0] compare_flag_out;
  logic update_flag_out;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int overlap_count;
  int seed = 32'h4540;
  int hi, rs, g, r, e;
  logic [31:0] cq; // counter read before a freeze
  // main 0..3, compl 4..6, compare flags 7..12, update flag 13
  wire [13:0] probe = {update_flag_out, compare_flag_out, compl_output, main_output};
  // dead-time cases and mode sequence with high cycles per 100
  localparam logic [7:0] DTG_TAB [6] = '{8'h05, 8'h05, 8'h05, 8'h82, 8'hC1, 8'hE0};
  localparam logic [1:0] CKD_TAB [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
  localparam logic [3:0] MODE_TAB [12] = '{4'h4, 4'h5, 4'h8, 4'h0, 4'h2, 4'h0,
    4'h1, 4'h3, 4'hC, 4'hD, 4'hE, 4'hF};
  localparam int HI_TAB [12] = '{0, 100, 100, 100, 0, 0, 100, 50, 50, 50, 30, 70};

  always #20 hclk = ~hclk;

  tocp_timer u_tocp_timer (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sync_in(sync_in), .main_output(main_output), .compl_output(compl_output),
    .compare_flag_out(compare_flag_out), .update_flag_out(update_flag_out));

  tocp_gate_model u_tocp_gate_model (.hclk(hclk), .hresetn(hresetn),
    .main_output(main_output), .compl_output(compl_output), .pair_on(pair_on),
    .overlap_count(overlap_count));

  // ==========
  // helpers
  // ==========
  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
    end
  end

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // single ahb-lite word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk(hresp, 1'b0, "hresp");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp, what);
  endtask

  // sync rise, then settle
  task automatic sync_pulse();
    sync_in <= 1'b1;
    @(posedge hclk);
    sync_in <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask

  // high cycles and rising edges of one probe bit, sampled mid-cycle
  task automatic measure(input int idx, input int n, output int h, output int rises);
    logic last;
    h = 0;
    rises = 0;
    @(negedge hclk);
    last = probe[idx];
    repeat (n)
    begin
      @(negedge hclk);
      h += (probe[idx] === 1'b1);
      rises += (probe[idx] === 1'b1 && last !== 1'b1);
      last = probe[idx];
    end
    @(posedge hclk);
  endtask

  // cycles from complementary fall to main rise
  task automatic dt_gap(output int gap);
    int t;
    t = 0;
    gap = 0;
    @(negedge hclk);
    while (compl_output[0] !== 1'b1 && t < 5000) begin @(negedge hclk); t++; end
    while (compl_output[0] !== 1'b0 && t < 5000) begin @(negedge hclk); t++; end
    while (main_output[0] !== 1'b1 && t < 5000) begin @(negedge hclk); t++; gap++; end
    @(posedge hclk);
  endtask

  // expected dead time in counter ticks
  function automatic int dt_expect(input logic [7:0] dtg, input logic [1:0] clock_division_field);
    int n;
    if (!dtg[7]) n = dtg;
    else if (!dtg[6]) n = (64 + dtg[5:0]) * 2;
    else if (!dtg[5]) n = (32 + dtg[4:0]) * 8;
    else n = (32 + dtg[4:0]) * 16;
    return n << clock_division_field;
  endfunction

  // ==========
  // main sequence
  // ==========
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values and an unmapped place
    rd_chk(`TOCP_OFF_ARR, 32'h0000FFFF, "period reset");
    rd_chk(`TOCP_OFF_IER, 32'h0, "irq enable reset");
    rd_chk(`TOCP_OFF_OEP, 32'h0, "enable word reset");
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h0, "unmapped");
    // flags on a ten-cycle period, masked then enabled
    wr(`TOCP_OFF_ARR, 32'h9);
    wr(`TOCP_OFF_CCR1, 32'h4);
    wr(8'h30, 32'h3);
    wr(`TOCP_OFF_DTB, 32'h00008000);
    for (r = 0; r < 2; r++)
    begin
      wr(`TOCP_OFF_IER, r ? 32'h1F : 32'h0);
      rd_chk(`TOCP_OFF_IER, r ? 32'h1F : 32'h0, "irq enable");
      sync_pulse();
      measure(13, 100, hi, rs);
      chk(hi, 10 * r, "update flags");
      chk(rs, hi, "update pulse");
      // all six compare flags, channels 5 and 6 never masked
      for (e = 7; e < 13; e++)
      begin
        measure(e, 100, hi, rs);
        chk(hi, (r || e > 10) ? 10 : 0, "compare flags");
        chk(rs, hi, "compare pulse");
        chk(rs, (r || e > 10) ? 10 : 0, "compare edges");
      end
    end
    // center-aligned counting, then down counting with a prescaler
    for (r = 0; r < 2; r++)
    begin
      wr(`TOCP_OFF_PSC, r);
      wr(`TOCP_OFF_CTRL, r ? 32'h10 : 32'h60);
      sync_pulse();
      measure(13, r ? 100 : 90, hi, rs);
      chk(hi, r ? 5 : 10, "update events per mode");
    end
    wr(`TOCP_OFF_PSC, 32'h0);
    wr(`TOCP_OFF_CTRL, 32'h0);
    // every supported mode but pwm 1 and 2, plus unsupported 1000, in turn, ch2 as pwm partner
    wr(`TOCP_OFF_OEP, 32'h1);
    wr(`TOCP_OFF_CCR1, 32'h3);
    wr(8'h24, 32'h5);
    for (r = 0; r < 12; r++)
    begin
      wr(`TOCP_OFF_MODE, {24'h0, 4'h6, MODE_TAB[r]});
      sync_pulse();
      measure(0, 100, hi, rs);
      chk(hi, HI_TAB[r], "mode duty");
    end
    // random duties in both pwm modes
    for (r = 0; r < 4; r++)
    begin
      e = ($random(seed) & 32'h7FFFFFFF) % 11;
      wr(`TOCP_OFF_CCR1, e);
      wr(`TOCP_OFF_MODE, r[0] ? 32'h7 : 32'h6);
      sync_pulse();
      measure(0, 100, hi, rs);
      chk(hi, r[0] ? 100 - 10 * e : 10 * e, "pwm duty");
    end
    // channel 1 gating by channel 5
    wr(`TOCP_OFF_CCR1, 32'h6);
    wr(`TOCP_OFF_MODE, 32'h00060006);
    for (r = 0; r < 2; r++)
    begin
      wr(8'h30, r ? 32'h00000003 : 32'h20000003);
      sync_pulse();
      measure(0, 100, hi, rs);
      chk(hi, r ? 60 : 30, "group combine");
    end
    // preloaded mode against immediate enable word
    wr(`TOCP_OFF_ARR, 32'h7FF);
    wr(`TOCP_OFF_MODE, 32'h4);
    sync_pulse();
    wr(`TOCP_OFF_MODE, 32'h5);
    repeat (5) @(posedge hclk);
    chk(main_output[0], 1'b0, "mode preloaded");
    sync_pulse();
    chk(main_output[0], 1'b1, "sync loads mode");
    // clock enable low freezes the counter between two reads
    bus(1'b0, `TOCP_OFF_CNT, 32'h0, cq);
    ce <= 1'b0;
    repeat (20) @(posedge hclk);
    ce <= 1'b1;
    rd_chk(`TOCP_OFF_CNT, cq + 32'h2, "frozen counter");
    wr(`TOCP_OFF_OEP, 32'h3);
    repeat (3) @(posedge hclk);
    chk(main_output[0], 1'b0, "polarity now");
    wr(`TOCP_OFF_OEP, 32'h0);
    wr(`TOCP_OFF_IDLE, 32'h1);
    repeat (3) @(posedge hclk);
    chk(main_output[0], 1'b1, "idle high");
    wr(`TOCP_OFF_IDLE, 32'h0);
    repeat (3) @(posedge hclk);
    chk(main_output[0], 1'b0, "idle low");
    // dead time per generator pattern and clock division
    wr(`TOCP_OFF_CCR1, 32'h400);
    wr(`TOCP_OFF_MODE, 32'h6);
    wr(`TOCP_OFF_OEP, 32'h5);
    pair_on <= 3'h1;
    for (r = 0; r < 6; r++)
    begin
      wr(`TOCP_OFF_DTB, 32'h00008000 | DTG_TAB[r]);
      wr(`TOCP_OFF_CTRL, {22'h0, CKD_TAB[r], 8'h0});
      sync_pulse();
      dt_gap(g);
      e = dt_expect(DTG_TAB[r], CKD_TAB[r]);
      chk(g, e, "dead time");
    end
    // single-sided enable pairs on every channel, channel 4 always on
    pair_on <= 3'h0;
    wr(8'h24, 32'h400);
    wr(8'h28, 32'h400);
    wr(8'h2C, 32'h400);
    wr(`TOCP_OFF_MODE, 32'h6666);
    for (r = 0; r < 2; r++)
    begin
      wr(`TOCP_OFF_OEP, r ? 32'h1444 : 32'h1111);
      sync_pulse();
      for (e = 0; e < 7; e++)
      begin
        measure(e, 2048, hi, rs);
        if (e < 4)
          chk(hi, (r && e < 3) ? 0 : 1024, "main of pair");
        else
          chk(hi, r ? 1024 : 0, "compl of pair");
      end
    end
    chk(overlap_count, 0, "overlap");
    give_verdict();
  end
endmodule
